// [das_agu.sv]
// Summary of operation
// - Read overflow from page 2FF goes to 300; underflow 300 to 2FF; bit 15 kept.
// - Overflow from 3FF, underflow from 001 or 200 clears bit 15, page kept.
// - Extended space read with read page zero raises an address error trap; writes do not.
// - Program space through the read page is read only; writes refused.
// - Addresses 0000-7FFF always reachable as page 0, whatever the page.
// - Read page register resets to 001.
// - Window pages other than 0 reached only with effective bit 15 set.
// - Register 15 is the stack pointer, auto updated, still a normal operand.
// - Stack pointer bit 0 is always zero.
// - Stack pointer resets to 1000.
// - Stack grows upward; push writes then increments, pop decrements then reads.
// - Program counter push: low 16 bits first, then bits 22:16.
// - Call pushes zero in the top byte of the second word.
// - Exception puts the status low byte in the top byte of the second word.
// - Stack pointer, and frame pointer while frame active, are never paged.
// - File register mode decodes a 13-bit direct address, first 8192 bytes.
// - File register results go to the file or working register 0.
// - Three-operand: second operand is memory via register or 5-bit literal.
// - Post-modified: pointer is the address, then pointer changes by constant.
// - Pre-modified: pointer plus signed constant first, then used as address.
// - Indexed: address is pointer plus base offset register.
// - Literal offset: address is pointer plus instruction literal.
// - Paged read with address bit 15 set gives page 8:0 joined with address 14:0.
// - General overflow increments page, underflow decrements, bit 15 set.
`default_nettype none
`include "das_cfg.svh"
module das_agu
  import das_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Register bus.
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // Address generation request from the decode.
  input wire logic ag_req_i,
  input wire das_mode_t ag_mode_i,
  input wire logic ag_write_i,
  input wire logic [3:0] ag_ptr_sel_i,
  input wire logic [15:0] ag_ptr_i,
  input wire logic [15:0] ag_ofs_i,
  input wire logic [15:0] ag_lit_i,
  input wire logic [12:0] ag_file_addr_i,
  input wire logic ag_to_default_work_reg_i,
  input wire logic [3:0] ag_dest_i,
  // Address generation answer.
  output logic ag_done_o,
  output logic [15:0] ag_ea_o,
  output logic [23:0] ag_addr_o,
  output logic ag_psv_o,
  output logic ag_mem_o,
  output logic ag_use_lit_o,
  output logic [15:0] ag_lit_val_o,
  output logic [3:0] ag_dest_sel_o,
  output logic ag_wb_en_o,
  output logic [15:0] ag_wb_val_o,
  output logic ag_addr_err_o,
  output logic ag_wr_err_o,
  // Stack requests.
  input wire logic sk_req_i,
  input wire das_sk_op_t sk_op_i,
  input wire logic [15:0] sk_wdata_i,
  input wire logic [22:0] sk_pc_i,
  input wire logic [7:0] sk_status_low_i,
  input wire logic sp_wr_i,
  input wire logic [15:0] sp_wdata_i,
  output logic sk_busy_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic [15:0] sw_stack_ptr_o
);

  typedef enum logic [2:0] {
    DAS_ST_IDLE,
    DAS_ST_PUSH_HI,
    DAS_ST_POP_LO,
    DAS_ST_DONE
  } das_st_t;

  logic [9:0] data_read_page_r;
  logic [15:0] sw_stack_ptr_r;
  logic frame_active_flag_r;
  logic [15:0] last_ea_r;
  logic [23:0] last_addr_r;
  logic wait_r;
  das_st_t st_r;
  logic [15:0] hi_word_r;

  // Bus handshake: one wait cycle, then a single acknowledge cycle.
  logic bus_req;
  logic bus_ack;
  logic bus_hit;
  logic [31:0] rd_mux;
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_ack = bus_req & ~wait_r;
  assign bus_hit = (avs_address_i[4:2] <= `DAS_REG_LAST_ADDR) &&
                   (avs_address_i[1:0] == 2'h0);

  // Paging applies to neither the stack pointer nor an active frame pointer.
  logic no_page;
  assign no_page = (ag_ptr_sel_i == `DAS_DEFAULT_WORK_REG_SP) ||
                   ((ag_ptr_sel_i == `DAS_DEFAULT_WORK_REG_FP) && frame_active_flag_r);

  // Address arithmetic with carry for boundary detection.
  logic [16:0] sum17;
  logic [15:0] ea_mod;
  logic ovf;
  logic unf;
  logic [15:0] adj;
  logic [9:0] page_nxt;
  logic [15:0] ea;
  logic [23:0] addr;
  logic program_space_window;
  logic aerr;
  logic werr;
  logic wb_en;
  logic [15:0] wb_val;
  logic is_mem;
  logic [15:0] lit_val;
  logic [3:0] dest;

  // Add pointer and modifier; the offset register replaces the literal
  // only in indexed mode.
  always_comb begin
    if (ag_mode_i == DAS_INDEXED) begin
      sum17 = {1'b0, ag_ptr_i} + {ag_ofs_i[15], ag_ofs_i};
    end else begin
      sum17 = {1'b0, ag_ptr_i} + {ag_lit_i[15], ag_lit_i};
    end
  end
  assign ea_mod = sum17[15:0];

  // A boundary crossing counts only when the starting address sat in the
  // upper half, so pointers into base data space are never disturbed.
  assign ovf = ag_ptr_i[`DAS_EA_UPPER_BIT] & ~ag_lit_i[15] &
               ~ea_mod[`DAS_EA_UPPER_BIT];
  assign unf = ag_ptr_i[`DAS_EA_UPPER_BIT] & ag_lit_i[15] &
               ~ea_mod[`DAS_EA_UPPER_BIT];

  // Boundary handling for pre- and post-modified reads.
  always_comb begin
    adj = ea_mod;
    page_nxt = data_read_page_r;
    if (!no_page && !ag_write_i && (ovf || unf) &&
        data_read_page_r != `DAS_PAGE_ZERO) begin
      adj[`DAS_EA_UPPER_BIT] = 1'b1;
      if (ovf) begin
        if (data_read_page_r == `DAS_PAGE_LSW_LAST) begin
          page_nxt = `DAS_PAGE_MSB_FIRST;
        end else if (data_read_page_r == `DAS_PAGE_MSB_LAST) begin
          adj[`DAS_EA_UPPER_BIT] = 1'b0;
        end else begin
          page_nxt = data_read_page_r + 10'h001;
        end
      end else begin
        if (data_read_page_r == `DAS_PAGE_MSB_FIRST) begin
          page_nxt = `DAS_PAGE_LSW_LAST;
        end else if (data_read_page_r == `DAS_PAGE_DATA_FIRST ||
                     data_read_page_r == `DAS_PAGE_PS_FIRST) begin
          adj[`DAS_EA_UPPER_BIT] = 1'b0;
        end else begin
          page_nxt = data_read_page_r - 10'h001;
        end
      end
    end
  end

  // Effective address, write-back and operand selection per mode.
  always_comb begin
    ea = ag_ptr_i;
    wb_en = 1'b0;
    wb_val = ag_ptr_i;
    is_mem = 1'b1;
    lit_val = 16'h0000;
    dest = ag_dest_i;
    case (ag_mode_i)
      DAS_FILE_DIRECT: begin
        ea = {3'h0, ag_file_addr_i};
        dest = ag_to_default_work_reg_i ? `DAS_DEFAULT_WORK_REG_DEFAULT : ag_dest_i;
      end
      DAS_REG_DIRECT: begin
        is_mem = 1'b0;
      end
      DAS_INDIRECT: begin
        ea = ag_ptr_i;
      end
      DAS_POST_MOD: begin
        ea = ag_ptr_i;
        wb_en = 1'b1;
        wb_val = adj;
      end
      DAS_PRE_MOD: begin
        ea = adj;
        wb_en = 1'b1;
        wb_val = adj;
      end
      DAS_INDEXED, DAS_LIT_OFS: begin
        // Offset forms wrap inside the current page and never move it.
        ea = ea_mod;
        if (ag_ptr_i[`DAS_EA_UPPER_BIT] && !no_page) begin
          ea[`DAS_EA_UPPER_BIT] = 1'b1;
        end
      end
      DAS_LIT5: begin
        is_mem = 1'b0;
        lit_val = {11'h000, ag_lit_i[4:0]};
      end
      default: begin
        is_mem = 1'b0;
      end
    endcase
    if (wb_en && ag_ptr_sel_i == `DAS_DEFAULT_WORK_REG_SP) begin
      wb_val[0] = 1'b0;
    end
  end

  // Final address: on reads, upper half plus the read page forms the paged address.
  always_comb begin
    addr = {8'h00, ea};
    program_space_window = 1'b0;
    aerr = 1'b0;
    werr = 1'b0;
    if (is_mem && ea[`DAS_EA_UPPER_BIT] && !no_page && !ag_write_i) begin
      addr = {data_read_page_r[8:0], ea[14:0]};
      program_space_window = data_read_page_r[`DAS_PAGE_PS_BIT];
      aerr = (data_read_page_r == `DAS_PAGE_ZERO);
    end
    if (is_mem && ea[`DAS_EA_UPPER_BIT] && !no_page && ag_write_i &&
        data_read_page_r[`DAS_PAGE_PS_BIT]) begin
      werr = 1'b1;
    end
  end

  // Answer to the decode, registered one cycle after the request.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ag_done_o <= 1'b0;
      ag_ea_o <= 16'h0000;
      ag_addr_o <= 24'h000000;
      ag_psv_o <= 1'b0;
      ag_mem_o <= 1'b0;
      ag_use_lit_o <= 1'b0;
      ag_lit_val_o <= 16'h0000;
      ag_dest_sel_o <= 4'h0;
      ag_wb_en_o <= 1'b0;
      ag_wb_val_o <= 16'h0000;
      ag_addr_err_o <= 1'b0;
      ag_wr_err_o <= 1'b0;
    end else begin
      ag_done_o <= ag_req_i;
      ag_addr_err_o <= ag_req_i & aerr;
      ag_wr_err_o <= ag_req_i & werr;
      ag_wb_en_o <= ag_req_i & wb_en;
      if (ag_req_i) begin
        ag_ea_o <= ea;
        ag_addr_o <= addr;
        ag_psv_o <= program_space_window;
        ag_mem_o <= is_mem;
        ag_use_lit_o <= (ag_mode_i == DAS_LIT5);
        ag_lit_val_o <= lit_val;
        ag_dest_sel_o <= dest;
        ag_wb_val_o <= wb_val;
      end
    end
  end

  // Read page register: decode-driven page moves win over a bus write
  // in the same cycle, so linear walks are never broken by software.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_read_page_r <= `DAS_PAGE_RST;
    end else if (ag_req_i && !ag_write_i &&
                 (ag_mode_i == DAS_PRE_MOD || ag_mode_i == DAS_POST_MOD)) begin
      data_read_page_r <= page_nxt;
    end else if (bus_ack && avs_write_i &&
                 avs_address_i[4:2] == `DAS_REG_PAGE && avs_byteenable_i[0] &&
                 avs_byteenable_i[1]) begin
      data_read_page_r <= avs_writedata_i[9:0];
    end
  end

  // Bookkeeping of the latest generated address for software.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_ea_r <= 16'h0000;
      last_addr_r <= 24'h000000;
    end else if (ag_req_i && is_mem) begin
      last_ea_r <= ea;
      last_addr_r <= addr;
    end
  end

  // Stack sequencer: push writes then increments, pop decrements then
  // reads. Program counter pushes take two cycles, low word first.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= DAS_ST_IDLE;
      sw_stack_ptr_r <= `DAS_SP_RST;
      hi_word_r <= 16'h0000;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
      sk_busy_o <= 1'b0;
    end else begin
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      case (st_r)
        DAS_ST_IDLE: begin
          if (sk_req_i) begin
            sk_busy_o <= 1'b1;
            case (sk_op_i)
              DAS_SK_PUSH: begin
                mem_wr_o <= 1'b1;
                mem_addr_o <= sw_stack_ptr_r;
                mem_wdata_o <= sk_wdata_i;
                sw_stack_ptr_r <= sw_stack_ptr_r + 16'h0002;
                st_r <= DAS_ST_DONE;
              end
              DAS_SK_CALL, DAS_SK_EXC: begin
                mem_wr_o <= 1'b1;
                mem_addr_o <= sw_stack_ptr_r;
                mem_wdata_o <= sk_pc_i[15:0];
                sw_stack_ptr_r <= sw_stack_ptr_r + 16'h0002;
                if (sk_op_i == DAS_SK_EXC) begin
                  hi_word_r <= {sk_status_low_i, 1'b0, sk_pc_i[22:16]};
                end else begin
                  hi_word_r <= {8'h00, 1'b0, sk_pc_i[22:16]};
                end
                st_r <= DAS_ST_PUSH_HI;
              end
              DAS_SK_POP: begin
                mem_rd_o <= 1'b1;
                mem_addr_o <= sw_stack_ptr_r - 16'h0002;
                sw_stack_ptr_r <= sw_stack_ptr_r - 16'h0002;
                st_r <= DAS_ST_DONE;
              end
              DAS_SK_RET: begin
                mem_rd_o <= 1'b1;
                mem_addr_o <= sw_stack_ptr_r - 16'h0002;
                sw_stack_ptr_r <= sw_stack_ptr_r - 16'h0002;
                st_r <= DAS_ST_POP_LO;
              end
              default: begin
                st_r <= DAS_ST_DONE;
              end
            endcase
          end else if (sp_wr_i) begin
            sw_stack_ptr_r <= {sp_wdata_i[15:1], 1'b0};
          end else if (bus_ack && avs_write_i &&
                       avs_address_i[4:2] == `DAS_REG_SP &&
                       avs_byteenable_i[0] && avs_byteenable_i[1]) begin
            sw_stack_ptr_r <= {avs_writedata_i[15:1], 1'b0};
          end
        end
        DAS_ST_PUSH_HI: begin
          mem_wr_o <= 1'b1;
          mem_addr_o <= sw_stack_ptr_r;
          mem_wdata_o <= hi_word_r;
          sw_stack_ptr_r <= sw_stack_ptr_r + 16'h0002;
          st_r <= DAS_ST_DONE;
        end
        DAS_ST_POP_LO: begin
          mem_rd_o <= 1'b1;
          mem_addr_o <= sw_stack_ptr_r - 16'h0002;
          sw_stack_ptr_r <= sw_stack_ptr_r - 16'h0002;
          st_r <= DAS_ST_DONE;
        end
        DAS_ST_DONE: begin
          sk_busy_o <= 1'b0;
          st_r <= DAS_ST_IDLE;
        end
        default: begin
          st_r <= DAS_ST_IDLE;
        end
      endcase
    end
  end

  // The stack pointer is always a plain 16-bit value, never paged.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_stack_ptr_o <= `DAS_SP_RST;
    end else begin
      sw_stack_ptr_o <= sw_stack_ptr_r;
    end
  end

  // Frame-active control bit.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_active_flag_r <= 1'b0;
    end else if (bus_ack && avs_write_i &&
                 avs_address_i[4:2] == `DAS_REG_CTRL && avs_byteenable_i[0]) begin
      frame_active_flag_r <= avs_writedata_i[0];
    end
  end

  // Read data selection; unused bits read as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_i[4:2])
      `DAS_REG_PAGE: rd_mux = {22'h000000, data_read_page_r};
      `DAS_REG_SP: rd_mux = {16'h0000, sw_stack_ptr_r};
      `DAS_REG_CTRL: rd_mux = {31'h00000000, frame_active_flag_r};
      `DAS_REG_LAST_EA: rd_mux = {16'h0000, last_ea_r};
      `DAS_REG_LAST_ADDR: rd_mux = {8'h00, last_addr_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Each request waits exactly one cycle; the answer edge drops wait for
  // one cycle so a held request is not answered again in the next cycle.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= 1'b1;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      avs_response_o <= `DAS_RESP_OK;
    end else begin
      wait_r <= ~(bus_req & wait_r);
      avs_waitrequest_o <= ~(bus_req & wait_r);
      if (bus_req && wait_r) begin
        avs_readdata_o <= (avs_read_i && bus_hit) ? rd_mux : 32'h00000000;
        avs_response_o <= bus_hit ? `DAS_RESP_OK : `DAS_RESP_DECERR;
      end
    end
  end

endmodule : das_agu
`default_nettype wire

// [das_cfg.svh]
`ifndef DAS_CFG_SVH
`define DAS_CFG_SVH

// Reset values, and page zero which traps on reads.
`define DAS_PAGE_RST 10'h001
`define DAS_SP_RST 16'h1000
`define DAS_PAGE_ZERO 10'h000

// Page boundary values where the paging exceptions apply.
`define DAS_PAGE_LSW_LAST 10'h2ff
`define DAS_PAGE_MSB_FIRST 10'h300
`define DAS_PAGE_MSB_LAST 10'h3ff
`define DAS_PAGE_PS_FIRST 10'h200
`define DAS_PAGE_DATA_FIRST 10'h001

// Field positions.
`define DAS_PAGE_PS_BIT 9
`define DAS_EA_UPPER_BIT 15
`define DAS_DEFAULT_WORK_REG_SP 4'hf
`define DAS_DEFAULT_WORK_REG_FP 4'he
`define DAS_DEFAULT_WORK_REG_DEFAULT 4'h0

// Register byte addresses on the bus (word index in address bits 4:2).
`define DAS_REG_PAGE 3'h0
`define DAS_REG_SP 3'h1
`define DAS_REG_CTRL 3'h2
`define DAS_REG_LAST_EA 3'h3
`define DAS_REG_LAST_ADDR 3'h4

// Bus response codes.
`define DAS_RESP_OK 2'h0
`define DAS_RESP_DECERR 2'h3

`endif

// [das_pkg.sv]
`default_nettype none
package das_pkg;

  // Addressing modes presented by the instruction decode.
  typedef enum logic [2:0] {
    DAS_FILE_DIRECT,
    DAS_REG_DIRECT,
    DAS_INDIRECT,
    DAS_POST_MOD,
    DAS_PRE_MOD,
    DAS_INDEXED,
    DAS_LIT_OFS,
    DAS_LIT5
  } das_mode_t;

  // Stack operations.
  typedef enum logic [2:0] {
    DAS_SK_PUSH,
    DAS_SK_POP,
    DAS_SK_CALL,
    DAS_SK_EXC,
    DAS_SK_RET
  } das_sk_op_t;

endpackage : das_pkg
`default_nettype wire

// [das_agu_props.sv]
`default_nettype none
module das_agu_props
  import das_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ag_req_i,
  input wire das_mode_t ag_mode_i,
  input wire logic [3:0] ag_ptr_sel_i,
  input wire logic [15:0] ag_ptr_i,
  input wire logic [15:0] ag_ofs_i,
  input wire logic [15:0] ag_lit_i,
  input wire logic [12:0] ag_file_addr_i,
  input wire logic ag_to_default_work_reg_i,
  input wire logic ag_done_o,
  input wire logic [15:0] ag_ea_o,
  input wire logic [23:0] ag_addr_o,
  input wire logic [3:0] ag_dest_sel_o,
  input wire logic ag_wb_en_o,
  input wire logic ag_addr_err_o,
  input wire logic sk_req_i,
  input wire das_sk_op_t sk_op_i,
  input wire logic [15:0] sk_wdata_i,
  input wire logic [22:0] sk_pc_i,
  input wire logic [7:0] sk_status_low_i,
  input wire logic sk_busy_o,
  input wire logic mem_wr_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic [15:0] sw_stack_ptr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sum_lit_r;
  logic [15:0] sum_ofs_r;
  logic [22:0] pc_r;
  logic [7:0] st_r;

  // Sums are taken every cycle, so the cycle after a request sees its own.
  always_ff @(posedge ref_clk_i) begin
    sum_lit_r <= ag_ptr_i + ag_lit_i;
    sum_ofs_r <= ag_ptr_i + ag_ofs_i;
  end

  // Only a taken stack request is latched; requests while busy are dropped.
  always_ff @(posedge ref_clk_i) begin
    if (sk_req_i && !sk_busy_o) begin
      pc_r <= sk_pc_i;
      st_r <= sk_status_low_i;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Request and stack frame steps.
  sequence s_ag(das_mode_t m);
    ag_req_i && ag_mode_i == m;
  endsequence
  sequence s_sk(das_sk_op_t o);
    sk_req_i && !sk_busy_o && sk_op_i == o;
  endsequence
  sequence s_lo;
    mem_wr_o && mem_wdata_o == pc_r[15:0];
  endsequence
  sequence s_hi(logic [7:0] b);
    mem_wr_o && mem_wdata_o == {b, 1'b0, pc_r[22:16]}
      && mem_addr_o == $past(mem_addr_o) + 16'h2;
  endsequence

  property p_post;
    s_ag(DAS_POST_MOD) |=> ag_wb_en_o && ag_ea_o == $past(ag_ptr_i);
  endproperty
  property p_pre;
    s_ag(DAS_PRE_MOD) |=> ag_wb_en_o && ag_ea_o == sum_lit_r;
  endproperty
  property p_idx;
    s_ag(DAS_INDEXED) |=> ag_ea_o == sum_ofs_r;
  endproperty
  property p_lofs;
    s_ag(DAS_LIT_OFS) |=> ag_ea_o == sum_lit_r;
  endproperty
  property p_file;
    s_ag(DAS_FILE_DIRECT) |=> ag_ea_o == {3'h0, $past(ag_file_addr_i)};
  endproperty
  property p_default_work_reg;
    s_ag(DAS_FILE_DIRECT) ##0 ag_to_default_work_reg_i |=> ag_dest_sel_o == 4'h0;
  endproperty
  property p_flat;
    ag_req_i && ag_ptr_sel_i == 4'hf
      && ag_mode_i inside {DAS_INDIRECT, DAS_POST_MOD, DAS_PRE_MOD}
      |=> ag_addr_o == {8'h00, ag_ea_o};
  endproperty
  property p_trap;
    ag_addr_err_o |-> ag_done_o && ag_ea_o[15];
  endproperty
  property p_even;
    sw_stack_ptr_o[0] == 1'b0;
  endproperty
  property p_call;
    s_sk(DAS_SK_CALL) |=> s_lo ##1 s_hi(8'h00);
  endproperty
  property p_exc;
    s_sk(DAS_SK_EXC) |=> s_lo ##1 s_hi(st_r);
  endproperty
  property p_push;
    s_sk(DAS_SK_PUSH) |=> mem_wr_o && mem_wdata_o == $past(sk_wdata_i);
  endproperty

  a_post: assert property (p_post)
    else $error("post modified address wrong");
  a_pre: assert property (p_pre)
    else $error("pre modified address wrong");
  a_idx: assert property (p_idx)
    else $error("indexed address wrong");
  a_lofs: assert property (p_lofs)
    else $error("literal offset address wrong");
  a_file: assert property (p_file)
    else $error("file register address wrong");
  a_default_work_reg: assert property (p_default_work_reg)
    else $error("file result not sent to register 0");
  a_flat: assert property (p_flat)
    else $error("stack pointer address was paged");
  a_trap: assert property (p_trap)
    else $error("address trap on lower half");
  a_even: assert property (p_even)
    else $error("stack pointer odd");
  a_call: assert property (p_call)
    else $error("call stack frame wrong");
  a_exc: assert property (p_exc)
    else $error("exception stack frame wrong");
  a_push: assert property (p_push)
    else $error("push data wrong");
endmodule : das_agu_props
bind das_agu das_agu_props u_props (.*);
`default_nettype wire

// [das_mem_model.sv]
`default_nettype none
module das_mem_model (
  input wire logic ref_clk_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [15:0] rd_a;

  // Small word store; high address bits alias, so keep tests in one area.
  always_ff @(posedge ref_clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i[6:1]] <= mem_wdata_i;
    end
    if (mem_rd_i) begin
      rd_a <= mem_addr_i;
    end
  end
endmodule : das_mem_model
`default_nettype wire

// [data_address_generation_and_stack_tb.sv]
`default_nettype none
module data_address_generation_and_stack_tb
  import das_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0;
  logic avs_write_i = 1'b0, ag_req_i = 1'b0, ag_write_i = 1'b0;
  logic ag_to_default_work_reg_i = 1'b0, sk_req_i = 1'b0, sp_wr_i = 1'b0;
  logic ag_done_o, ag_psv_o, ag_mem_o, ag_use_lit_o, ag_wb_en_o;
  logic ag_addr_err_o, ag_wr_err_o, sk_busy_o, avs_waitrequest_o;
  logic mem_wr_o, mem_rd_o;
  logic [4:0] avs_address_i = 5'h00;
  logic [3:0] avs_byteenable_i = 4'hf, ag_ptr_sel_i = 4'h0;
  logic [3:0] ag_dest_i = 4'h0, ag_dest_sel_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [1:0] avs_response_o, rsp;
  logic [15:0] ag_ptr_i = 16'h0, ag_ofs_i = 16'h0, ag_lit_i = 16'h0;
  logic [15:0] sk_wdata_i = 16'h0, sp_wdata_i = 16'h0;
  logic [15:0] ag_ea_o, ag_lit_val_o, ag_wb_val_o, mem_addr_o;
  logic [15:0] mem_wdata_o, sw_stack_ptr_o;
  logic [12:0] ag_file_addr_i = 13'h0;
  logic [23:0] ag_addr_o;
  logic [22:0] sk_pc_i = 23'h0;
  logic [7:0] sk_status_low_i = 8'h0;
  das_mode_t ag_mode_i = DAS_FILE_DIRECT;
  das_sk_op_t sk_op_i = DAS_SK_PUSH;
  int n_errors = 0, total_checks = 0;
  logic [9:0] pg_in [6] = '{10'h2ff, 10'h3ff, 10'h300, 10'h001, 10'h200,
    10'h100};
  logic [9:0] pg_out [6] = '{10'h300, 10'h3ff, 10'h2ff, 10'h001, 10'h200,
    10'h101};
  logic [15:0] wb_exp [6] = '{16'h8000, 16'h0000, 16'hfffe, 16'h7ffe,
    16'h7ffe, 16'h8000};

  das_agu DUT (.*);
  das_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_wr_i(mem_wr_o),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o));

  // Free running 100 MHz clock.
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One bus cycle; the request stands until waitrequest is sampled low.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  // One address request; outputs are looked at mid cycle after the answer.
  task ag(input das_mode_t m, input logic w, input logic [3:0] s,
    input logic [15:0] p, l);
    @(posedge ref_clk_i);
    ag_mode_i <= m;
    ag_write_i <= w;
    ag_ptr_sel_i <= s;
    ag_ptr_i <= p;
    ag_lit_i <= l;
    ag_req_i <= 1'b1;
    @(posedge ref_clk_i);
    ag_req_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask : ag

  // One stack operation, then the pointer is read back over the bus.
  task skc(input das_sk_op_t o, input logic [22:0] pc, input logic [15:0] e);
    @(posedge ref_clk_i);
    sk_op_i <= o;
    sk_pc_i <= pc;
    sk_req_i <= 1'b1;
    @(posedge ref_clk_i);
    sk_req_i <= 1'b0;
    do @(negedge ref_clk_i); while (sk_busy_o !== 1'b0);
    bus(1'b0, 5'h04, 32'h0);
    chk("sp", {16'h0, e}, q);
  endtask : skc

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog; the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    give_verdict();
  end

  // Main sequence of tests.
  initial begin
    logic up;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    bus(1'b0, 5'h00, 32'h0);
    chk("page", 32'h001, q);
    bus(1'b0, 5'h04, 32'h0);
    chk("sp", 32'h1000, q);
    bus(1'b0, 5'h14, 32'h0);
    chk("resp", 32'h3, {30'h0, rsp});
    $display("test reset done");
    sk_wdata_i <= 16'h5555;
    sk_status_low_i <= 8'ha5;
    skc(DAS_SK_CALL, 23'h7abcde, 16'h1004);
    chk("lo", 32'hbcde, {16'h0, u_mem.mem[0]});
    chk("hi", 32'h007a, {16'h0, u_mem.mem[1]});
    skc(DAS_SK_EXC, 23'h012345, 16'h1008);
    chk("lo", 32'h2345, {16'h0, u_mem.mem[2]});
    chk("hi", 32'ha501, {16'h0, u_mem.mem[3]});
    skc(DAS_SK_PUSH, 23'h0, 16'h100a);
    chk("push", 32'h5555, {16'h0, u_mem.mem[4]});
    skc(DAS_SK_POP, 23'h0, 16'h1008);
    chk("pop", 32'h1008, {16'h0, u_mem.rd_a});
    skc(DAS_SK_RET, 23'h0, 16'h1004);
    chk("ret", 32'h1004, {16'h0, u_mem.rd_a});
    @(posedge ref_clk_i);
    sp_wdata_i <= 16'h3003;
    sp_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sp_wr_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("sp_o", 32'h3002, {16'h0, sw_stack_ptr_o});
    bus(1'b1, 5'h04, 32'h2001);
    bus(1'b0, 5'h04, 32'h0);
    chk("sp", 32'h2000, q);
    $display("test stack done");
    for (int i = 0; i < 6; i++) begin
      up = i inside {2, 3, 4};
      bus(1'b1, 5'h00, {22'h0, pg_in[i]});
      ag(DAS_POST_MOD, 1'b0, 4'h1, up ? 16'h8000 : 16'hfffe,
        up ? 16'hfffe : 16'h0002);
      chk("addr", {8'h0, pg_in[i][8:0], ag_ptr_i[14:0]},
        {8'h0, ag_addr_o});
      chk("wb", {16'h0, wb_exp[i]}, {16'h0, ag_wb_val_o});
      bus(1'b0, 5'h00, 32'h0);
      chk("page", {22'h0, pg_out[i]}, q);
    end
    $display("test paging done");
    bus(1'b1, 5'h00, 32'h0);
    ag(DAS_INDIRECT, 1'b0, 4'h1, 16'h8000, 16'h0);
    chk("trap", 32'h1, {31'h0, ag_addr_err_o});
    ag(DAS_INDIRECT, 1'b0, 4'h1, 16'h1234, 16'h0);
    chk("trap", 32'h0, {31'h0, ag_addr_err_o});
    chk("addr", 32'h001234, {8'h0, ag_addr_o});
    bus(1'b1, 5'h00, 32'h201);
    ag(DAS_INDIRECT, 1'b1, 4'h1, 16'h8010, 16'h0);
    chk("wr_err", 32'h1, {31'h0, ag_wr_err_o});
    chk("addr", 32'h008010, {8'h0, ag_addr_o});
    ag(DAS_INDIRECT, 1'b0, 4'h1, 16'h8010, 16'h0);
    chk("addr", 32'h008010, {8'h0, ag_addr_o});
    chk("psv", 32'h1, {31'h0, ag_psv_o});
    bus(1'b1, 5'h08, 32'h1);
    for (int i = 14; i < 16; i++) begin
      bus(1'b1, 5'h00, 32'h2ff);
      ag(DAS_POST_MOD, 1'b0, i[3:0], 16'hfffe, 16'h0002);
      chk("addr", 32'h00fffe, {8'h0, ag_addr_o});
      bus(1'b0, 5'h00, 32'h0);
      chk("page", 32'h2ff, q);
    end
    $display("test traps done");
    ag_ofs_i <= 16'h0102;
    ag(DAS_INDEXED, 1'b0, 4'h2, 16'h1000, 16'h0);
    chk("ea", 32'h1102, {16'h0, ag_ea_o});
    ag(DAS_LIT_OFS, 1'b0, 4'h2, 16'h1000, 16'hfff0);
    chk("ea", 32'h0ff0, {16'h0, ag_ea_o});
    ag(DAS_PRE_MOD, 1'b0, 4'h2, 16'h1000, 16'hfffe);
    chk("ea", 32'h0ffe, {16'h0, ag_ea_o});
    chk("wb", 32'h0ffe, {16'h0, ag_wb_val_o});
    ag(DAS_POST_MOD, 1'b0, 4'h2, 16'h1000, 16'h0002);
    chk("ea", 32'h1000, {16'h0, ag_ea_o});
    chk("wb", 32'h1002, {16'h0, ag_wb_val_o});
    ag_file_addr_i <= 13'h1fff;
    ag_to_default_work_reg_i <= 1'b1;
    ag(DAS_FILE_DIRECT, 1'b0, 4'h2, 16'h0, 16'h0);
    chk("ea", 32'h1fff, {16'h0, ag_ea_o});
    chk("dest", 32'h0, {28'h0, ag_dest_sel_o});
    ag_to_default_work_reg_i <= 1'b0;
    ag_dest_i <= 4'h5;
    ag(DAS_FILE_DIRECT, 1'b0, 4'h2, 16'h0, 16'h0);
    chk("dest", 32'h5, {28'h0, ag_dest_sel_o});
    ag(DAS_REG_DIRECT, 1'b0, 4'h2, 16'h0, 16'h0);
    chk("mem", 32'h0, {31'h0, ag_mem_o});
    ag(DAS_LIT5, 1'b0, 4'h2, 16'h0, 16'h0015);
    chk("use_lit", 32'h1, {31'h0, ag_use_lit_o});
    chk("lit", 32'h0015, {16'h0, ag_lit_val_o});
    $display("test modes done");
    give_verdict();
  end
endmodule : data_address_generation_and_stack_tb
`default_nettype wire
